// *** logic/reset_strap_cfg.svh ***
`ifndef RESET_STRAP_CFG_SVH
`define RESET_STRAP_CFG_SVH

`define MODE_SERIAL_PERIPHERAL 1'b0
`define MODE_TWO_WIRE 1'b1
`define MODE_RESET_VALUE 1'b0
`define RATIO_BIT0_RESET_VALUE 1'b0
`define SYNC_STAGES 2

`endif

// *** logic/reset_strap_pkg.sv ***
package reset_strap_pkg;
	typedef enum logic [2:0] {
		ST_HELD = 3'h1,
		ST_SERIAL = 3'h2,
		ST_TWO_WIRE = 3'h4
	} seq_state_t;
endpackage

// *** logic/reset_and_strap_latch.sv ***
// Behaviour
// - Serial mode: low pin resets whole chip
// - Reset low returns registers to defaults
// - No serial communication during reset
// - Internal clocks gated off during reset
// - Pin reset equals power-on reset state except bias, which follows clock
// - Analog biases stay on with clock
// - Two-wire mode: pin is ratio bit0
// - Capture ratio bit0 on two-wire entry
// - Recapture ratio bit0 on watchdog reset
// - Sample mode input after any reset
// - Latched mode low serial, high two-wire
`include "reset_strap_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module reset_and_strap_latch (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_reset_or_ratio_strap_pin,
	input wire logic i_mode_select,
	input wire logic i_watchdog_expired,
	input wire logic i_master_clock_present,
	output logic o_chip_reset,
	output logic o_comm_enable,
	output logic o_clock_enable,
	output logic o_analog_bias_enable,
	output logic o_two_wire_mode,
	output logic o_oversample_select_bit0
);
	// Registers and next values
	reset_strap_pkg::seq_state_t state_q;
	reset_strap_pkg::seq_state_t state_d;
	logic [`SYNC_STAGES-1:0] rel_sync_q;
	logic [`SYNC_STAGES-1:0] rel_sync_d;
	logic mode_q;
	logic mode_d;
	logic ratio_q;
	logic ratio_d;
	logic resample_q;
	logic resample_d;
	logic chip_reset_q;
	logic chip_reset_d;
	logic comm_q;
	logic comm_d;
	logic clk_en_q;
	logic clk_en_d;
	logic bias_q;
	logic bias_d;

	// Decode nets
	wire logic rst_release;
	wire logic pin_reset_req;
	wire logic held;
	wire logic enter_two_wire;
	wire logic wd_reset;
	wire logic capture_ratio;
	wire logic clear_ratio;

	// Mode strap decode
	function automatic logic is_two_wire(input logic mode);
		return mode == `MODE_TWO_WIRE;
	endfunction

	// Strap and reset decode
	assign rst_release = rel_sync_q[`SYNC_STAGES-1];
	assign pin_reset_req = !is_two_wire(mode_q) && !i_reset_or_ratio_strap_pin;
	assign held = !rst_release || pin_reset_req;
	assign enter_two_wire = resample_q && is_two_wire(i_mode_select);
	assign wd_reset = is_two_wire(mode_q) && i_watchdog_expired;
	assign capture_ratio = enter_two_wire || wd_reset;
	assign clear_ratio = held && !is_two_wire(mode_d);

	// Next values of the registers
	assign rel_sync_d = {rel_sync_q[`SYNC_STAGES-2:0], 1'b1};
	assign resample_d = held || wd_reset;
	assign chip_reset_d = held;
	assign comm_d = !held;
	assign clk_en_d = !held;
	assign bias_d = !held || i_master_clock_present;

	// Mode resampled every cycle resample_q is set: through each reset and one cycle after
	always_comb begin
		mode_d = mode_q;
		if (resample_q) begin
			mode_d = i_mode_select;
		end
	end

	// Ratio strap cleared in reset while mode_d is serial, else captured on two-wire entry or watchdog reset
	always_comb begin
		ratio_d = ratio_q;
		if (clear_ratio) begin
			ratio_d = `RATIO_BIT0_RESET_VALUE;
		end else if (capture_ratio) begin
			ratio_d = i_reset_or_ratio_strap_pin;
		end
	end

	// Async assert, clocked release of internal reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rel_sync_q <= '0;
		end else begin
			rel_sync_q <= rel_sync_d;
		end
	end

	// Mode resample request
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			resample_q <= 1'b1;
		end else begin
			resample_q <= resample_d;
		end
	end

	// Interface sequencer
	always_comb begin
		case (state_q)
			reset_strap_pkg::ST_HELD: begin
				if (held) begin
					state_d = reset_strap_pkg::ST_HELD;
				end else if (mode_q == `MODE_TWO_WIRE) begin
					state_d = reset_strap_pkg::ST_TWO_WIRE;
				end else begin
					state_d = reset_strap_pkg::ST_SERIAL;
				end
			end
			reset_strap_pkg::ST_SERIAL: begin
				if (held || mode_q == `MODE_TWO_WIRE) begin
					state_d = reset_strap_pkg::ST_HELD;
				end else begin
					state_d = reset_strap_pkg::ST_SERIAL;
				end
			end
			reset_strap_pkg::ST_TWO_WIRE: begin
				if (!rst_release || mode_q == `MODE_SERIAL_PERIPHERAL) begin
					state_d = reset_strap_pkg::ST_HELD;
				end else begin
					state_d = reset_strap_pkg::ST_TWO_WIRE;
				end
			end
			default: begin
				state_d = reset_strap_pkg::ST_HELD;
			end
		endcase
	end

	// Sequencer state register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= reset_strap_pkg::ST_HELD;
		end else begin
			state_q <= state_d;
		end
	end

	// Latched interface mode
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_q <= `MODE_RESET_VALUE;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Latched ratio strap bit0
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ratio_q <= `RATIO_BIT0_RESET_VALUE;
		end else begin
			ratio_q <= ratio_d;
		end
	end

	// Internal chip reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			chip_reset_q <= 1'b1;
		end else begin
			chip_reset_q <= chip_reset_d;
		end
	end

	// Serial communication enable
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			comm_q <= 1'b0;
		end else begin
			comm_q <= comm_d;
		end
	end

	// Internal clock distribution enable
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			clk_en_q <= 1'b0;
		end else begin
			clk_en_q <= clk_en_d;
		end
	end

	// Analog bias enable
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bias_q <= 1'b0;
		end else begin
			bias_q <= bias_d;
		end
	end

	// Registered outputs
	assign o_chip_reset = chip_reset_q;
	assign o_comm_enable = comm_q;
	assign o_clock_enable = clk_en_q;
	assign o_analog_bias_enable = bias_q;
	assign o_two_wire_mode = mode_q;
	assign o_oversample_select_bit0 = ratio_q;
endmodule
`default_nettype wire

// *** bench/reset_strap_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module reset_strap_checker (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_reset_or_ratio_strap_pin,
	input wire logic i_watchdog_expired,
	input wire logic o_chip_reset,
	input wire logic o_comm_enable,
	input wire logic o_clock_enable,
	input wire logic o_analog_bias_enable,
	input wire logic o_two_wire_mode,
	input wire logic o_oversample_select_bit0
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_hold; !o_two_wire_mode && !o_chip_reset && !i_reset_or_ratio_strap_pin |=> o_chip_reset; endproperty
	a_hold: assert property (p_hold) else $error("no hold");
	property p_gate; o_chip_reset |-> !o_comm_enable && !o_clock_enable; endproperty
	a_gate: assert property (p_gate) else $error("gate");
	property p_def; o_chip_reset && !i_reset_or_ratio_strap_pin |=> !o_oversample_select_bit0; endproperty
	a_def: assert property (p_def) else $error("default");
	property p_bias; !o_chip_reset |-> o_analog_bias_enable; endproperty
	a_bias: assert property (p_bias) else $error("bias");
	property p_wire; o_two_wire_mode && !o_chip_reset && !i_watchdog_expired |=> !o_chip_reset; endproperty
	a_wire: assert property (p_wire) else $error("pin reset");
	property p_wdog; o_two_wire_mode && i_watchdog_expired |-> ##2 o_oversample_select_bit0 == $past(i_reset_or_ratio_strap_pin); endproperty
	a_wdog: assert property (p_wdog) else $error("recapture");
	property p_entry; $rose(o_two_wire_mode) |-> o_oversample_select_bit0 == $past(i_reset_or_ratio_strap_pin); endproperty
	a_entry: assert property (p_entry) else $error("capture");
	property p_fell; $fell(o_chip_reset) && !o_two_wire_mode |-> o_comm_enable && o_clock_enable; endproperty
	a_fell: assert property (p_fell) else $error("release");
endmodule
`default_nettype wire

// *** bench/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic i_clk
);
	logic p = 1'b1, m = 1'b0, w = 1'b0, c = 1'b1;
	task set(input logic np, nm, nw, nc);
		@(posedge i_clk);
		p <= np;
		m <= nm;
		w <= nw;
		c <= nc;
	endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clk = 1'b0, i_rst = 1'b1;
	wire logic [5:0] q;
	int err_count = 0, total_checks = 0;
	always #2.5 i_clk = ~i_clk;
	host_model h (.i_clk(i_clk));
	reset_and_strap_latch i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_reset_or_ratio_strap_pin(h.p), .i_mode_select(h.m),
		.i_watchdog_expired(h.w), .i_master_clock_present(h.c), .o_chip_reset(q[5]), .o_comm_enable(q[4]),
		.o_clock_enable(q[3]), .o_analog_bias_enable(q[2]), .o_two_wire_mode(q[1]), .o_oversample_select_bit0(q[0]));
	task chk(input logic [5:0] e, input logic [5:0] k);
		total_checks++;
		if ((q & k) !== e) begin
			err_count++;
			$display("BAD outputs exp %b got %b", e, q);
		end
	endtask
	task finish_test;
		$display("errors %0d checks %0d", err_count, total_checks);
		if (err_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task t_por(input logic m, input logic b);
		h.set(b, m, 0, 1);
		i_rst <= 1'b1;
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (6) @(posedge i_clk);
		#1 chk({1'b0, 1'b1, 2'b11, m, m & b}, 6'h3F);
	endtask
	task t_hold(input logic c);
		h.set(0, 0, 0, c);
		repeat (2) @(posedge i_clk);
		#1 chk({3'b100, c, 2'b00}, 6'h3F);
		h.set(1, 0, 0, c);
		repeat (3) @(posedge i_clk);
		#1 chk(6'h1C, 6'h3F);
	endtask
	task t_two(input logic b);
		t_por(1, b);
		h.set(!b, 1, 0, 1);
		repeat (3) @(posedge i_clk);
		#1 chk({5'b01111, b}, 6'h3F);
		h.set(!b, 1, 1, 1);
		h.set(!b, 1, 0, 1);
		repeat (3) @(posedge i_clk);
		#1 chk({5'b01111, !b}, 6'h3F);
	endtask
	initial begin
		t_por(0, 1);
		t_hold(1);
		t_hold(0);
		t_two(0);
		t_two(1);
		finish_test();
	end
	initial begin
		#5000;
		err_count++;
		finish_test();
	end
endmodule
bind reset_and_strap_latch reset_strap_checker i_chk (.*);
`default_nettype wire
